// *** src/lrc_params.svh ***
// Register offsets, field positions, reset values for the regulator bank
// Functional notes
// - HW-control opmode 00/10 low power, 01 off, 11 follows ON opmode; reset 10.
// - Output-float bit clear discharges disabled output, set leaves it floating.
// - Low-power class 0 picks 50 mA variant, 1 picks 20 mA variant.
// - Low-power class applies in ON, SLEEP and hardware-control low power.
// - ON slot 000 never enables; 001..101 enable in timeslot 1..5.
// - ON slot 110 follows hardware enable 1, 111 follows hardware enable 2.
// - ON opmode bit: 0 normal, 1 low power while ON; resets 0.
// - ON voltage code, 50 mV steps to 1.60 V then 100 mV steps.
// - SLEEP slot 000/110/111 apply sleep settings in timeslot 5/3/1.
// - SLEEP slot 001..101 disable in timeslot 5..1 on sleep entry.
// - With hardware enable, codes 001..101 pick sleep-entry timeslot instead.
// - SLEEP opmode bit: 0 normal, 1 low power while asleep; resets 1.
// - SLEEP voltage code uses the same mapping as the ON code.
// - Undervoltage action: 00 ignore, 01 regulator off, 10 device reset.
// - Every unmasked undervoltage fault raises an interrupt whatever the action.
// - Second channel HW source: 00 off, 01 input 1, 10 input 2, 11 either.
// - HW-control voltage bit: 0 ON code, 1 SLEEP code.
// - First channel HW source field gates its HW mode and voltage fields.
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH

`define LRC_IDX_CTRL_A 16'h406E
`define LRC_IDX_ON_A 16'h406F
`define LRC_IDX_SLP_A 16'h4070
`define LRC_IDX_CTRL_B 16'h4071
`define LRC_IDX_IRQ_STAT 16'h4080
`define LRC_IDX_IRQ_MASK 16'h4081

`define LRC_MASK_CTRL 16'hDFC1
`define LRC_MASK_SLOT 16'hE11F
`define LRC_MASK_IRQ 16'h0003

`define LRC_RST_CTRL 16'h0200
`define LRC_RST_ON 16'h0000
`define LRC_RST_SLP 16'h0100
`define LRC_RST_IRQ 16'h0000

`define LRC_F_ACT 15:14
`define LRC_F_SRC 12:11
`define LRC_F_VPICK 10
`define LRC_F_HWMODE 9:8
`define LRC_F_FLT 7
`define LRC_F_SWI 6
`define LRC_F_LPCLS 0
`define LRC_F_SLOT 15:13
`define LRC_F_MODE 8
`define LRC_F_VSEL 4:0

`define LRC_B_UV_A 0
`define LRC_B_UV_B 1

`endif

// *** src/lrc_pkg.sv ***
// Types shared by the regulator control bank
package lrc_pkg;
	typedef logic [4:0] lrc_vcode_t;
	typedef logic [2:0] lrc_slot_t;
	typedef enum logic [1:0] {
		LRC_ACT_IGNORE = 2'b00,
		LRC_ACT_REG_OFF = 2'b01,
		LRC_ACT_SYS_RESET = 2'b10,
		LRC_ACT_RESERVED = 2'b11
	} lrc_uvact_e;
	typedef enum logic [1:0] {
		LRC_HWM_LP0 = 2'b00,
		LRC_HWM_OFF = 2'b01,
		LRC_HWM_LP2 = 2'b10,
		LRC_HWM_FOLLOW = 2'b11
	} lrc_hwmode_e;
	typedef enum logic [1:0] {
		LRC_SRC_NONE = 2'b00,
		LRC_SRC_IN1 = 2'b01,
		LRC_SRC_IN2 = 2'b10,
		LRC_SRC_ANY = 2'b11
	} lrc_src_e;
endpackage

// *** src/lrc_regs.sv ***
// APB register bank and channel control for one regulator plus neighbour
`include "lrc_params.svh"

module lrc_regs
	import lrc_pkg::*;
(
	input wire logic pclk, // Register clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [17:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte lanes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic hwctl_in1, // Hardware control input 1
	input wire logic hwctl_in2, // Hardware control input 2
	input wire logic hw_enable1, // Hardware enable input 1
	input wire logic hw_enable2, // Hardware enable input 2
	input wire logic start_slot_pulse, // Start-up timeslot strobe
	input wire logic sleep_slot_pulse, // Sleep timeslot strobe
	input wire logic [2:0] seq_slot, // Timeslot number, 1..5
	input wire logic wake_pulse, // Leave sleep
	input wire logic uv_fault_a, // Undervoltage, first channel
	input wire logic uv_fault_b, // Undervoltage, second channel
	output logic irq, // Interrupt, level
	output logic reg_a_enable, // First regulator enabled
	output logic reg_a_lowpower, // First regulator in low power
	output logic reg_a_lp_min_iq, // Low power uses 20 mA variant
	output logic reg_a_discharge, // Active output discharge
	output logic reg_a_switch_mode, // Switch mode selected
	output logic [4:0] reg_a_vout_code, // Voltage code in effect
	output logic reg_b_hwctl_active, // Second channel under HW control
	output logic reg_b_hwctl_use_sleep, // Second channel HW uses SLEEP code
	output logic reg_b_shutdown, // Second regulator shut by fault
	output logic sys_reset_req // Device reset request
);

	logic [15:0] ctrl_a_q;
	logic [15:0] on_a_q;
	logic [15:0] slp_a_q;
	logic [15:0] ctrl_b_q;
	logic [1:0] stat_q;
	logic [15:0] mask_q;
	logic on_q;
	logic on_d;
	logic asleep_q;
	logic asleep_d;
	logic uv_off_q;
	logic b_off_q;
	logic sysrst_q;

	// Bus decode
	wire word_ok = paddr[1:0] == 2'b00;
	wire [15:0] idx = paddr[17:2];
	wire hit_ctrl_a = word_ok && idx == `LRC_IDX_CTRL_A;
	wire hit_on_a = word_ok && idx == `LRC_IDX_ON_A;
	wire hit_slp_a = word_ok && idx == `LRC_IDX_SLP_A;
	wire hit_ctrl_b = word_ok && idx == `LRC_IDX_CTRL_B;
	wire hit_stat = word_ok && idx == `LRC_IDX_IRQ_STAT;
	wire hit_mask = word_ok && idx == `LRC_IDX_IRQ_MASK;
	wire mapped = hit_ctrl_a | hit_on_a | hit_slp_a | hit_ctrl_b |
		hit_stat | hit_mask;
	wire setup = psel && !penable && !pready;
	wire commit = psel && penable && pready;
	wire wr = commit && pwrite && !pslverr;
	wire [15:0] lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] msk);
		merge = ((old & ~lanes) | (pwdata[15:0] & lanes)) & msk;
	endfunction

	wire [15:0] rd_word =
		hit_ctrl_a ? ctrl_a_q :
		hit_on_a ? on_a_q :
		hit_slp_a ? slp_a_q :
		hit_ctrl_b ? ctrl_b_q :
		hit_stat ? {14'h0000, stat_q} :
		hit_mask ? mask_q : 16'h0000;

	// Answer one cycle after setup: zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
				prdata <= {16'h0000, rd_word};
		end
	end

	// Register storage; reserved code 11 kept as written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_q <= `LRC_RST_CTRL;
			on_a_q <= `LRC_RST_ON;
			slp_a_q <= `LRC_RST_SLP;
			ctrl_b_q <= `LRC_RST_CTRL;
			mask_q <= `LRC_RST_IRQ;
		end else if (wr) begin
			if (hit_ctrl_a)
				ctrl_a_q <= merge(ctrl_a_q, `LRC_MASK_CTRL);
			if (hit_on_a)
				on_a_q <= merge(on_a_q, `LRC_MASK_SLOT);
			if (hit_slp_a)
				slp_a_q <= merge(slp_a_q, `LRC_MASK_SLOT);
			if (hit_ctrl_b)
				ctrl_b_q <= merge(ctrl_b_q, `LRC_MASK_CTRL);
			if (hit_mask)
				mask_q <= merge(mask_q, `LRC_MASK_IRQ);
		end
	end

	// Sticky fault flags, write one to clear; a new fault wins the clear
	wire [1:0] uv_evt = {uv_fault_b, uv_fault_a};
	wire [1:0] stat_clr = (wr && hit_stat) ?
		(pwdata[1:0] & {2{pstrb[0]}}) : 2'b00;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_stat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					stat_q[gi] <= 1'b0;
				else if (uv_evt[gi])
					stat_q[gi] <= 1'b1;
				else if (stat_clr[gi])
					stat_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// Mask bit set suppresses that source
	wire irq_d = |(stat_q[1:0] & ~mask_q[1:0]);

	// First channel fields, plus the second channel's source and action
	wire [2:0] on_slot = on_a_q[`LRC_F_SLOT];
	wire [2:0] slp_slot = slp_a_q[`LRC_F_SLOT];
	wire on_mode = on_a_q[`LRC_F_MODE];
	wire slp_mode = slp_a_q[`LRC_F_MODE];
	wire [4:0] on_v = on_a_q[`LRC_F_VSEL];
	wire [4:0] slp_v = slp_a_q[`LRC_F_VSEL];
	wire [1:0] src_a = ctrl_a_q[`LRC_F_SRC];
	wire [1:0] src_b = ctrl_b_q[`LRC_F_SRC];
	wire [1:0] hwmode_a = ctrl_a_q[`LRC_F_HWMODE];
	wire [1:0] act_a = ctrl_a_q[`LRC_F_ACT];
	wire [1:0] act_b = ctrl_b_q[`LRC_F_ACT];

	function automatic logic hw_source(input logic [1:0] src);
		unique case (lrc_src_e'(src))
			LRC_SRC_NONE: hw_source = 1'b0;
			LRC_SRC_IN1: hw_source = hwctl_in1;
			LRC_SRC_IN2: hw_source = hwctl_in2;
			LRC_SRC_ANY: hw_source = hwctl_in1 | hwctl_in2;
		endcase
	endfunction

	wire hwctl_a = hw_source(src_a);
	wire hwctl_b = hw_source(src_b);

	// Start-up: 110 and 111 hand the enable to a hardware pin
	wire hw_assigned = on_slot[2] & on_slot[1];
	wire hw_en_sel = on_slot[0] ? hw_enable2 : hw_enable1;
	wire sw_slot = on_slot != 3'b000 && !hw_assigned;
	wire start_hit = start_slot_pulse && sw_slot &&
		seq_slot == on_slot;

	// Sleep timeslot; disable codes run in reverse order
	wire slp_disable_code = slp_slot != 3'b000 &&
		!(slp_slot[2] & slp_slot[1]);
	wire [2:0] slp_tslot =
		slp_slot == 3'b000 ? 3'd5 :
		slp_slot == 3'b110 ? 3'd3 :
		slp_slot == 3'b111 ? 3'd1 :
		3'(3'd6 - slp_slot);
	wire sleep_hit = sleep_slot_pulse && seq_slot == slp_tslot;
	// A pin-enabled regulator only enters sleep, never disables here
	wire sleep_off = sleep_hit && slp_disable_code && !hw_assigned;

	// Undervoltage response; reserved and ignore do nothing
	wire uv_shut_a = uv_fault_a &&
		lrc_uvact_e'(act_a) == LRC_ACT_REG_OFF;
	wire uv_shut_b = uv_fault_b &&
		lrc_uvact_e'(act_b) == LRC_ACT_REG_OFF;
	wire uv_sys = (uv_fault_a &&
		lrc_uvact_e'(act_a) == LRC_ACT_SYS_RESET) ||
		(uv_fault_b && lrc_uvact_e'(act_b) == LRC_ACT_SYS_RESET);

	always_comb begin
		on_d = on_q;
		if (start_hit)
			on_d = 1'b1;
		if (sleep_off || uv_shut_a)
			on_d = 1'b0;
		asleep_d = asleep_q;
		if (sleep_hit && !sleep_off)
			asleep_d = 1'b1;
		if (wake_pulse)
			asleep_d = 1'b0;
	end

	// Fault shutdown of a pin-enabled regulator holds until software rewrites the ON register
	wire on_rewrite = wr && hit_on_a;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q <= 1'b0;
			asleep_q <= 1'b0;
			uv_off_q <= 1'b0;
		end else begin
			on_q <= on_d;
			asleep_q <= asleep_d;
			if (uv_shut_a)
				uv_off_q <= 1'b1;
			else if (on_rewrite)
				uv_off_q <= 1'b0;
		end
	end

	wire base_en = hw_assigned ? (hw_en_sel && !uv_off_q) : on_q;

	// Hardware control overrides ON and SLEEP settings
	wire hw_off = lrc_hwmode_e'(hwmode_a) == LRC_HWM_OFF;
	wire hw_lp = lrc_hwmode_e'(hwmode_a) == LRC_HWM_FOLLOW ?
		on_mode : 1'b1;
	wire en_eff = base_en && !(hwctl_a && hw_off);
	wire lp_eff = hwctl_a ? hw_lp :
		asleep_q ? slp_mode : on_mode;
	wire [4:0] v_eff = hwctl_a ?
		(ctrl_a_q[`LRC_F_VPICK] ? slp_v : on_v) :
		asleep_q ? slp_v : on_v;

	// Output flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			reg_a_enable <= 1'b0;
			reg_a_lowpower <= 1'b0;
			reg_a_lp_min_iq <= 1'b0;
			reg_a_discharge <= 1'b1;
			reg_a_switch_mode <= 1'b0;
			reg_a_vout_code <= 5'h00;
		end else begin
			irq <= irq_d;
			reg_a_enable <= en_eff;
			reg_a_lowpower <= en_eff && lp_eff;
			reg_a_lp_min_iq <= en_eff && lp_eff &&
				ctrl_a_q[`LRC_F_LPCLS];
			reg_a_discharge <= !en_eff &&
				!ctrl_a_q[`LRC_F_FLT];
			reg_a_switch_mode <= ctrl_a_q[`LRC_F_SWI];
			reg_a_vout_code <= v_eff;
		end
	end

	// Second channel: only its control register lives here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_b_hwctl_active <= 1'b0;
			reg_b_hwctl_use_sleep <= 1'b0;
			b_off_q <= 1'b0;
			sysrst_q <= 1'b0;
		end else begin
			reg_b_hwctl_active <= hwctl_b;
			reg_b_hwctl_use_sleep <= hwctl_b &&
				ctrl_b_q[`LRC_F_VPICK];
			if (uv_shut_b)
				b_off_q <= 1'b1;
			else if (wr && hit_ctrl_b)
				b_off_q <= 1'b0;
			sysrst_q <= uv_sys;
		end
	end

	assign reg_b_shutdown = b_off_q;
	assign sys_reset_req = sysrst_q;

endmodule

// *** bench/lrc_regs_asserts.sv ***
// Port-level assertions for the regulator control bank
module lrc_regs_asserts (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access
	input wire logic pwrite, // APB direction
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic uv_fault_a, // Fault a
	input wire logic uv_fault_b, // Fault b
	input wire logic irq, // Interrupt
	input wire logic reg_a_enable, // Enabled
	input wire logic reg_a_lowpower, // Low power
	input wire logic reg_a_lp_min_iq, // 20 mA class
	input wire logic reg_a_discharge, // Discharge
	input wire logic reg_b_hwctl_active, // HW control b
	input wire logic reg_b_hwctl_use_sleep, // HW voltage pick b
	input wire logic reg_b_shutdown, // Shutdown b
	input wire logic sys_reset_req // Device reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_zero_wait: assert property (
		pready |-> psel && penable && $past(psel) && !$past(penable)
		##1 !pready)
		else $error("pready outside a single access cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_hold: assert property (
		!$stable(prdata) |->
		$past(psel) && !$past(penable) && !$past(pwrite))
		else $error("prdata changed without a read setup");
	// Status sets one edge after the cause, irq one edge later still
	a_irq_cause: assert property (
		$rose(irq) |-> $past(uv_fault_a, 2) || $past(uv_fault_b, 2) ||
		$past(psel, 2) && $past(penable, 2))
		else $error("irq rose without fault or write");
	a_discharge_off: assert property (
		reg_a_discharge |-> !reg_a_enable)
		else $error("discharge while enabled");
	a_lowpower_on: assert property (
		reg_a_lowpower |-> reg_a_enable)
		else $error("low power while disabled");
	a_class_in_lp: assert property (
		reg_a_lp_min_iq |-> reg_a_lowpower)
		else $error("low power class outside low power");
	a_pick_active: assert property (
		reg_b_hwctl_use_sleep |-> reg_b_hwctl_active)
		else $error("voltage pick without hardware control");
	a_sysrst_cause: assert property (
		sys_reset_req |-> $past(uv_fault_a) || $past(uv_fault_b))
		else $error("device reset request without fault");
	a_shutdown_cause: assert property (
		$rose(reg_b_shutdown) |-> $past(uv_fault_b))
		else $error("shutdown without fault b");
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the regulator control bank
`include "lrc_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'h3;
	logic hwctl_in1 = '0, hwctl_in2 = '0, hw_enable1 = '0, hw_enable2 = '0;
	logic [2:0] seq_slot = 3'h1, c;
	logic [4:0] ev = '0, reg_a_vout_code;
	wire start_slot_pulse = ev[0];
	wire sleep_slot_pulse = ev[1];
	wire wake_pulse = ev[2];
	wire uv_fault_a = ev[3];
	wire uv_fault_b = ev[4];
	logic pready, pslverr, irq, sys_reset_req, err, reg_a_enable;
	logic reg_a_lowpower, reg_a_lp_min_iq, reg_a_discharge, reg_a_switch_mode;
	logic reg_b_hwctl_active, reg_b_hwctl_use_sleep, reg_b_shutdown;
	logic [2:0] slp_slot [8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
	int fail_count = 0, samples_checked = 0, rst_cnt = 0, i, k;
	lrc_regs DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.hwctl_in1(hwctl_in1), .hwctl_in2(hwctl_in2),
		.hw_enable1(hw_enable1), .hw_enable2(hw_enable2),
		.start_slot_pulse(start_slot_pulse),
		.sleep_slot_pulse(sleep_slot_pulse), .seq_slot(seq_slot),
		.wake_pulse(wake_pulse), .uv_fault_a(uv_fault_a),
		.uv_fault_b(uv_fault_b), .irq(irq),
		.reg_a_enable(reg_a_enable),
		.reg_a_lowpower(reg_a_lowpower),
		.reg_a_lp_min_iq(reg_a_lp_min_iq),
		.reg_a_discharge(reg_a_discharge),
		.reg_a_switch_mode(reg_a_switch_mode),
		.reg_a_vout_code(reg_a_vout_code),
		.reg_b_hwctl_active(reg_b_hwctl_active),
		.reg_b_hwctl_use_sleep(reg_b_hwctl_use_sleep),
		.reg_b_shutdown(reg_b_shutdown),
		.sys_reset_req(sys_reset_req)
	);
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (sys_reset_req === 1'b1) rst_cnt++;
	task automatic end_of_test();
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Held until pready is sampled high, then released; idle cycles follow
	task automatic apb(input logic w, input logic [15:0] idx, d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic wr(input logic [15:0] idx, d);
		apb(1'b1, idx, d);
	endtask
	task automatic rc(input logic [15:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 16'h0000);
		chk("register", e, rd);
	endtask
	task automatic fire(input logic [4:0] e, input logic [2:0] s);
		seq_slot <= s;
		ev <= e;
		@(posedge pclk);
		ev <= '0;
		repeat (3) @(posedge pclk);
	endtask
	initial begin
		#200000;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("discharge", 32'h1, reg_a_discharge);
		rc(`LRC_IDX_CTRL_A, 32'h0200);
		rc(`LRC_IDX_ON_A, 32'h0000);
		rc(`LRC_IDX_SLP_A, 32'h0100);
		rc(`LRC_IDX_CTRL_B, 32'h0200);
		wr(`LRC_IDX_CTRL_A, 16'hFFFF);
		rc(`LRC_IDX_CTRL_A, 32'hDFC1);
		chk("switch", 32'h1, reg_a_switch_mode);
		chk("discharge", 32'h0, reg_a_discharge);
		apb(1'b0, 16'h4072, 16'h0000);
		chk("slverr", 32'h1, err);
		wr(`LRC_IDX_CTRL_A, 16'h0001);
		wr(`LRC_IDX_ON_A, 16'h210E);
		fire(5'h01, 3'h2);
		chk("enable", 32'h0, reg_a_enable);
		fire(5'h01, 3'h1);
		chk("enable", 32'h1, reg_a_enable);
		chk("lowpower", 32'h1, reg_a_lowpower);
		chk("min_iq", 32'h1, reg_a_lp_min_iq);
		chk("vout", 32'h0E, reg_a_vout_code);
		for (i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(`LRC_IDX_SLP_A, {c, 13'h011F});
			fire(5'h01, 3'h1);
			fire(5'h02, slp_slot[i] == 3'h1 ? 3'h2 : 3'h1);
			chk("early", 32'h0E, reg_a_vout_code);
			fire(5'h02, slp_slot[i]);
			chk("sleep_en", c == 0 || c > 5, reg_a_enable);
			if (c == 0 || c > 5) begin
				chk("sleep_v", 32'h1F, reg_a_vout_code);
				chk("sleep_lp", 32'h1, reg_a_lp_min_iq);
			end
			fire(5'h04, 3'h1);
		end
		for (i = 0; i < 2; i++) begin
			wr(`LRC_IDX_ON_A, {2'h3, i[0], 13'h0000});
			hw_enable1 <= !i[0];
			hw_enable2 <= i[0];
			repeat (4) @(posedge pclk);
			chk("hw_en", 32'h1, reg_a_enable);
			hw_enable1 <= 1'b0;
			hw_enable2 <= 1'b0;
			repeat (4) @(posedge pclk);
			chk("hw_en", 32'h0, reg_a_enable);
		end
		hw_enable2 <= 1'b1;
		wr(`LRC_IDX_SLP_A, 16'h211F);
		fire(5'h02, 3'h5);
		chk("hw_sleep", 32'h1, reg_a_enable);
		chk("hw_sleep_v", 32'h1F, reg_a_vout_code);
		fire(5'h04, 3'h1);
		hw_enable2 <= 1'b0;
		wr(`LRC_IDX_ON_A, 16'h2000);
		fire(5'h01, 3'h1);
		hwctl_in1 <= 1'b1;
		for (i = 0; i < 5; i++) begin
			wr(`LRC_IDX_CTRL_A, {4'h0, i < 4, 1'b1, i[1:0], 8'h00});
			chk("hwctl_en", i != 1, reg_a_enable);
			chk("hwctl_lp", i == 0 || i == 2, reg_a_lowpower);
			chk("hwctl_class", 32'h0, reg_a_lp_min_iq);
			chk("hwctl_v", i < 4 ? 32'h1F : 32'h00, reg_a_vout_code);
		end
		for (i = 0; i < 8; i++) begin
			hwctl_in1 <= !i[2];
			hwctl_in2 <= i[2];
			wr(`LRC_IDX_CTRL_B, {3'h0, i[1:0], 11'h400});
			chk("b_active", i[2] ? i[1] : i[0], reg_b_hwctl_active);
			chk("b_pick", i[2] ? i[1] : i[0], reg_b_hwctl_use_sleep);
		end
		wr(`LRC_IDX_CTRL_A, 16'h0000);
		for (i = 0; i < 4; i++) begin
			wr(`LRC_IDX_CTRL_B, {i[1:0], 14'h0000});
			k = rst_cnt;
			fire(5'h10, 3'h1);
			chk("irq", 32'h1, irq);
			chk("shutdown", i == 1, reg_b_shutdown);
			chk("sys_reset", i == 2, rst_cnt - k);
			rc(`LRC_IDX_CTRL_B, {16'h0000, i[1:0], 14'h0000});
			wr(`LRC_IDX_IRQ_STAT, 16'h0003);
			chk("irq_clear", 32'h0, irq);
		end
		wr(`LRC_IDX_IRQ_MASK, 16'h0001);
		fire(5'h08, 3'h1);
		chk("irq_masked", 32'h0, irq);
		rc(`LRC_IDX_IRQ_STAT, 32'h0001);
		wr(`LRC_IDX_IRQ_MASK, 16'h0000);
		chk("irq_unmasked", 32'h1, irq);
		wr(`LRC_IDX_IRQ_STAT, 16'h0001);
		chk("irq_clear", 32'h0, irq);
		end_of_test();
	end
endmodule
bind lrc_regs lrc_regs_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .uv_fault_a(uv_fault_a), .uv_fault_b(uv_fault_b),
	.irq(irq), .reg_a_enable(reg_a_enable),
	.reg_a_lowpower(reg_a_lowpower), .reg_a_lp_min_iq(reg_a_lp_min_iq),
	.reg_a_discharge(reg_a_discharge),
	.reg_b_hwctl_active(reg_b_hwctl_active),
	.reg_b_hwctl_use_sleep(reg_b_hwctl_use_sleep),
	.reg_b_shutdown(reg_b_shutdown), .sys_reset_req(sys_reset_req)
);
